// File: rtl/wawc_pkg.sv
// Constants, types and the timeout decode for the watchdog and wake-up block.
// Assumes a single bus clock; the oscillator tick arrives as a one-cycle
// strobe already synchronous to that clock.
package wawc_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_RSTSRC  = 8'h04;
    localparam logic [7:0] OFF_STATUS  = 8'h08;
    localparam logic [7:0] OFF_WAKE_EN = 8'h0c;
    localparam logic [7:0] OFF_WAKE_POL = 8'h10;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int         KEY_LSB    = 3;
    localparam int         SEL_LSB    = 0;
    localparam logic [7:0] CTRL_POR   = 8'h53;
    localparam logic [4:0] KEY_ENABLE  = 5'h0a;
    localparam logic [4:0] KEY_DISABLE = 5'h15;
    localparam int         RSF_CORRUPT_BIT = 0;
    localparam int         ST_TO_BIT   = 0;
    localparam int         ST_PDF_BIT  = 1;
    localparam int         ST_HALT_BIT = 2;
    localparam int         CORRUPT_TICKS_DEF = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_HALT = 2'b10
    } wawc_state_t;

    // Instruction and core events, one-cycle strobes except stack_full
    typedef struct packed {
        logic clear_watchdog_instruction_instr;
        logic halt_instr;
        logic usb_reset;
        logic stack_full;
    } wawc_core_t;

    // Terminal count for each timeout select code (ticks minus one)
    function automatic logic [17:0] wawc_limit(input logic [2:0] sel);
        logic [17:0] lim;
        lim = 18'h3ffff;
        case (sel)
            3'h0:    lim = 18'h000ff;
            3'h1:    lim = 18'h003ff;
            3'h2:    lim = 18'h00fff;
            3'h3:    lim = 18'h03fff;
            3'h4:    lim = 18'h07fff;
            3'h5:    lim = 18'h0ffff;
            3'h6:    lim = 18'h1ffff;
            default: lim = 18'h3ffff;
        endcase
        return lim;
    endfunction

endpackage

// File: rtl/wawc_top.sv
// Watchdog timer with key-protected enable, corruption reset and the
// sleep/idle wake-up decision for the core.
// Assumes an AHB-Lite master, a core that strobes its clear and halt
// instructions, and an oscillator tick synchronous to hclk.
//
// Notes on behaviour
// R1 - Counter advances on the low-speed oscillator tick, dividing 2^8..2^18.
// R2 - Select codes 0..7 give 2^8,10,12,14,15,16,17,18 ticks.
// R3 - Key 10101 disables the watchdog, key 01010 enables it.
// R4 - Any other key resets the MCU after a delay and sets corruption flag.
// R5 - After power on the key is 01010 and select is 011.
// R6 - Corruption flag set only by corruption reset, cleared only by software zero.
// R7 - Overflow while running requests a device reset and sets time-out flag.
// R8 - Overflow while halted sets time-out flag and resets only PC and SP.
// R9 - Counter clears on corruption, clear instruction, halt, or reset pin low.
// R10 - Halted core wakes on pin reset, USB reset, pin edge, interrupt, overflow.
// R11 - Pin or USB reset wake gives full reset; overflow wake gives watchdog reset.
// R12 - Power-down flag clears on power-up and clear instruction, sets on halt.
// R13 - Each pin may wake on its active edge; execution resumes after halt.
// R14 - Disabled or stack-full interrupt wake resumes after halt, request stays pending.
// R15 - Enabled interrupt with free stack gets its normal response at wake.
// R16 - Interrupt already requested at halt cannot wake the core.
// R17 - Power-on reset holds the program counter at zero.
// R18 - Halt clears the counter; it runs on only if enabled.
// R19 - Halt clears the time-out flag and sets the power-down flag.
// R20 - Corruption delay is a parameter count of ticks ending in reset request.
// R21 - Overflow when counter reaches selected count; select change applies next compare.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.

`timescale 1ns/100ps
`default_nettype none

module wawc_top
    import wawc_pkg::*;
#(
    parameter int PINS          = 8,
    parameter int IRQS          = 8,
    parameter int CORRUPT_TICKS = CORRUPT_TICKS_DEF
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              ce,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              watchdog_tick,
    input  wire wawc_core_t        core_ev,
    input  wire logic              external_reset_pin_n,
    input  wire logic [PINS-1:0]   wake_pins,
    input  wire logic [IRQS-1:0]   irq_req,
    input  wire logic [IRQS-1:0]   irq_en,
    output logic                   mcu_reset_req,
    output logic                   pc_sp_reset,
    output logic                   resume_after_halt,
    output logic      [IRQS-1:0]   irq_service,
    output logic                   core_halted
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    // Reads take one wait state so a read straight after a write to the
    // same register sees the new value.
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [7:0]  addr_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;
    logic        hresp_r;

    wire addr_ok = hsel & hready & htrans[1];
    wire rd_req  = addr_ok & ~hwrite;
    wire wr_req  = addr_ok & hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r   <= 1'b0;
            rd_pend_r   <= 1'b0;
            addr_r      <= 8'h00;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end else if (ce) begin
            wr_pend_r   <= wr_req;
            rd_pend_r   <= rd_req;
            hreadyout_r <= ~rd_req;
            hresp_r     <= 1'b0;
            if (addr_ok) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    wire wr_ctrl = wr_pend_r & (addr_r == OFF_CTRL);
    wire wr_rsf  = wr_pend_r & (addr_r == OFF_RSTSRC);
    wire wr_wen  = wr_pend_r & (addr_r == OFF_WAKE_EN);
    wire wr_wpol = wr_pend_r & (addr_r == OFF_WAKE_POL);

    // ------------------------------------------------------------------
    // Control register and key decode
    // ------------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] cor_cnt_r;
    logic       wrf_r;

    wire [4:0] key_field = ctrl_r[KEY_LSB +: 5];
    wire [2:0] sel_field = ctrl_r[SEL_LSB +: 3];
    // R3 - key decode
    wire key_en  = (key_field == KEY_ENABLE);
    wire key_dis = (key_field == KEY_DISABLE);
    wire key_bad = ~key_en & ~key_dis;

    // R20 - corruption delay ends
    wire corrupt_fire = key_bad & watchdog_tick &
                        (cor_cnt_r == 8'(CORRUPT_TICKS - 1));

    // R4 - corruption reloads defaults
    // R5 - power-on defaults
    assign ctrl_nxt = corrupt_fire ? CTRL_POR :
                      wr_ctrl      ? hwdata[7:0] : ctrl_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= CTRL_POR;
        end else if (ce) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // R20 - tick-counted delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cor_cnt_r <= 8'h00;
        end else if (ce) begin
            if (!key_bad || corrupt_fire) begin
                cor_cnt_r <= 8'h00;
            end else if (watchdog_tick) begin
                cor_cnt_r <= cor_cnt_r + 8'h01;
            end
        end
    end

    // R6 - sticky, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wrf_r <= 1'b0;
        end else if (ce) begin
            if (corrupt_fire) begin
                wrf_r <= 1'b1;
            end else if (wr_rsf && !hwdata[RSF_CORRUPT_BIT]) begin
                wrf_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Watchdog counter
    // ------------------------------------------------------------------
    logic [17:0] cnt_r;

    // R2 - timeout decode
    wire [17:0] cnt_limit = wawc_limit(sel_field);
    // R9 - four clearing events
    wire clr_src  = core_ev.clear_watchdog_instruction_instr | core_ev.halt_instr |
                    ~external_reset_pin_n | corrupt_fire;
    // R1 - counts oscillator ticks
    // R18 - stopped while disabled
    wire tick_run = watchdog_tick & key_en;
    // R21 - compare against current select; >= absorbs a shrunk select
    wire ovf      = tick_run & (cnt_r >= cnt_limit) & ~clr_src;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 18'h00000;
        end else if (ce) begin
            if (clr_src || ovf) begin
                cnt_r <= 18'h00000;
            end else if (tick_run) begin
                cnt_r <= cnt_r + 18'h00001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Wake pin configuration and edge detect
    // ------------------------------------------------------------------
    logic [PINS-1:0] wake_en_r;
    logic [PINS-1:0] wake_pol_r;
    logic [PINS-1:0] pin_prev_r;
    logic [PINS-1:0] pin_edge;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_en_r  <= '0;
            wake_pol_r <= '0;
            pin_prev_r <= '0;
        end else if (ce) begin
            pin_prev_r <= wake_pins;
            if (wr_wen) begin
                wake_en_r <= hwdata[PINS-1:0];
            end
            if (wr_wpol) begin
                wake_pol_r <= hwdata[PINS-1:0];
            end
        end
    end

    // R13 - per-pin active edge
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            assign pin_edge[gi] = wake_en_r[gi] &
                (wake_pol_r[gi] ? (wake_pins[gi] & ~pin_prev_r[gi])
                                : (~wake_pins[gi] & pin_prev_r[gi]));
        end
    endgenerate

    wire pin_wake = |pin_edge;

    // ------------------------------------------------------------------
    // Halt state and wake decision
    // ------------------------------------------------------------------
    wawc_state_t     state_r;
    wawc_state_t     state_nxt;
    logic [IRQS-1:0] irq_armed_r;
    logic            mcu_reset_req_r;
    logic            pc_sp_reset_r;
    logic            resume_r;
    logic [IRQS-1:0] irq_service_r;
    logic            to_r;
    logic            pdf_r;

    wire in_run  = (state_r == ST_RUN);
    wire in_halt = (state_r == ST_HALT);
    wire halt_go = in_run & core_ev.halt_instr;

    // R16 - only requests raised after halt
    wire [IRQS-1:0] irq_wake = irq_req & irq_armed_r;
    wire            irq_any  = |irq_wake;
    // R15 - enabled with free stack
    wire [IRQS-1:0] irq_take = irq_wake & irq_en;
    wire            serve    = (|irq_take) & ~core_ev.stack_full;

    // R10 - five wake sources
    wire w_rst  = ~external_reset_pin_n | core_ev.usb_reset;
    wire w_soft = ~w_rst & ~ovf;
    wire wake   = in_halt & (w_rst | ovf | pin_wake | irq_any);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (core_ev.halt_instr) begin
                    state_nxt = ST_HALT;
                end
            end
            ST_HALT: begin
                if (wake) begin
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    // R7 - running overflow resets device
    // R11 - reset-type wake
    // R4 - corruption reset request
    wire mcu_rst_nxt  = corrupt_fire | (in_run & ovf) | (in_halt & w_rst);
    // R8 - halted overflow resets PC and SP only
    wire pc_sp_nxt    = in_halt & ovf & ~w_rst;
    // R13 - pin wake resumes after halt
    // R14 - unserved interrupt resumes after halt
    wire resume_nxt   = in_halt & w_soft & ~serve & (pin_wake | irq_any);
    wire [IRQS-1:0] service_nxt = (in_halt & w_soft & serve) ? irq_take
                                                              : '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r         <= ST_RUN;
            irq_armed_r     <= '0;
            mcu_reset_req_r <= 1'b0;
            // R17 - PC held at zero through power-on
            pc_sp_reset_r   <= 1'b1;
            resume_r        <= 1'b0;
            irq_service_r   <= '0;
        end else if (ce) begin
            state_r         <= state_nxt;
            mcu_reset_req_r <= mcu_rst_nxt;
            pc_sp_reset_r   <= pc_sp_nxt;
            resume_r        <= resume_nxt;
            irq_service_r   <= service_nxt;
            if (halt_go) begin
                irq_armed_r <= ~irq_req;
            end
        end
    end

    // ------------------------------------------------------------------
    // Time-out and power-down flags
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            to_r  <= 1'b0;
            pdf_r <= 1'b0;
        end else if (ce) begin
            // R7 - set on overflow
            // R19 - halt clears time-out
            if (ovf) begin
                to_r <= 1'b1;
            end else if (halt_go) begin
                to_r <= 1'b0;
            end
            // R12 - power-down flag
            if (halt_go) begin
                pdf_r <= 1'b1;
            end else if (core_ev.clear_watchdog_instruction_instr) begin
                pdf_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    wire [31:0] rd_mux =
        (addr_r == OFF_CTRL)     ? {24'h000000, ctrl_r} :
        (addr_r == OFF_RSTSRC)   ? {31'h0, wrf_r} :
        (addr_r == OFF_STATUS)   ? {29'h0, in_halt, pdf_r, to_r} :
        (addr_r == OFF_WAKE_EN)  ? 32'(wake_en_r) :
        (addr_r == OFF_WAKE_POL) ? 32'(wake_pol_r) : 32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
        end else if (ce && rd_pend_r) begin
            hrdata_r <= rd_mux;
        end
    end

    assign hrdata            = hrdata_r;
    assign hreadyout         = hreadyout_r;
    assign hresp             = hresp_r;
    assign mcu_reset_req     = mcu_reset_req_r;
    assign pc_sp_reset       = pc_sp_reset_r;
    assign resume_after_halt = resume_r;
    assign irq_service       = irq_service_r;
    assign core_halted       = state_r[1];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_corrupt_reload: assert property ((ce && corrupt_fire) |=> // R4
        (ctrl_r == CTRL_POR) && wrf_r && mcu_reset_req_r)
        else $error("corruption did not reload and request reset");
    a_corrupt_delay: assert property ((ce && key_bad && !watchdog_tick) // R20
        |=> $stable(cor_cnt_r))
        else $error("corruption delay moved without a tick");
    a_flag_sticky: assert property ( // R6
        ($past(wrf_r) && !$past(wr_rsf && !hwdata[RSF_CORRUPT_BIT]))
        |-> wrf_r)
        else $error("corruption flag lost without software clear");
    a_run_ovf_reset: assert property ((ce && in_run && ovf) |=> // R7
        mcu_reset_req_r && to_r && !pc_sp_reset_r)
        else $error("running overflow missed device reset");
    a_halt_ovf_pcsp: assert property ((ce && in_halt && ovf && !w_rst) // R8
        |=> pc_sp_reset_r && to_r && !mcu_reset_req_r && in_run)
        else $error("halted overflow did not reset only PC and SP");
    a_cnt_cleared: assert property ( // R9
        (ce && (core_ev.clear_watchdog_instruction_instr || !external_reset_pin_n))
        |=> (cnt_r == 18'h00000))
        else $error("watchdog counter not cleared");
    a_disabled_hold: assert property ((ce && key_dis) |=> // R18
        (cnt_r == 18'h00000) || $stable(cnt_r))
        else $error("disabled watchdog counter moved");
    a_ovf_at_limit: assert property ( // R2
        (ce && tick_run && !clr_src && (cnt_r == cnt_limit - 18'h00001))
        |=> (cnt_r == cnt_limit))
        else $error("counter wrapped before selected limit");
    a_wake_reset: assert property ((ce && in_halt && w_rst) |=> // R11
        mcu_reset_req_r && in_run && !resume_r)
        else $error("reset wake did not give full reset");
    a_halt_flags: assert property ((ce && halt_go) |=> // R19
        pdf_r && !to_r && in_halt && (cnt_r == 18'h00000))
        else $error("halt did not set power-down and clear time-out");
    a_clr_pdf: assert property ( // R12
        (ce && core_ev.clear_watchdog_instruction_instr && !halt_go) |=> !pdf_r)
        else $error("clear instruction kept power-down flag");
    a_pin_resume: assert property ( // R13
        (ce && in_halt && pin_wake && w_soft && !serve)
        |=> resume_r && in_run)
        else $error("pin wake did not resume after halt");
    a_irq_service: assert property ((ce && in_halt && w_soft && serve) // R15
        |=> (irq_service_r != '0) && !resume_r)
        else $error("enabled interrupt wake not serviced");
    a_stale_irq: assert property ( // R16
        (ce && in_halt && !irq_any && !pin_wake && !w_rst && !ovf)
        |=> in_halt)
        else $error("stale interrupt woke the core");

endmodule

`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the watchdog and wake-up block.
// Assumes a single-slave AHB-Lite bus and a tick strobe synchronous to hclk.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import wawc_pkg::*;

    // Short corruption delay keeps the run brief
    localparam int CT = 3;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        ce = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        tick = 1'b0;
    wawc_core_t  core_ev = '0;
    logic        rst_pin_n = 1'b1;
    logic [7:0]  pins = 8'h0;
    logic [7:0]  irq_req = 8'h0;
    logic [7:0]  irq_en = 8'h0;
    logic        mcu_reset_req;
    logic        pc_sp_reset;
    logic        resume;
    logic [7:0]  irq_service;
    logic        core_halted;
    logic [7:0]  svc_seen = 8'h0;
    logic [31:0] q;
    int          cnt [4];
    int          error_cnt = 0;
    int          samples_checked = 0;

    always #10 hclk = ~hclk;

    wawc_top #(.PINS(8), .IRQS(8), .CORRUPT_TICKS(CT)) u_wawc_top (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .watchdog_tick(tick),
        .core_ev(core_ev), .external_reset_pin_n(rst_pin_n),
        .wake_pins(pins), .irq_req(irq_req), .irq_en(irq_en),
        .mcu_reset_req(mcu_reset_req), .pc_sp_reset(pc_sp_reset),
        .resume_after_halt(resume), .irq_service(irq_service),
        .core_halted(core_halted));

    // Pulses are counted mid-cycle, away from the launching edge
    always @(negedge hclk) begin
        cnt[0] += int'(mcu_reset_req === 1'b1);
        cnt[1] += int'(pc_sp_reset === 1'b1);
        cnt[2] += int'(resume === 1'b1);
        cnt[3] += int'(irq_service != 8'h0);
        if (irq_service != 8'h0) svc_seen = irq_service;
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // One single word transfer; ready is sampled where it has settled
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        logic r;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do begin
            @(negedge hclk);
            r = hreadyout;
            @(posedge hclk);
        end while (!r);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(negedge hclk);
            r = hreadyout;
            q = hrdata;
            @(posedge hclk);
        end while (!r);
    endtask

    task automatic rd(input string n, input logic [7:0] a,
                      input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, q);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            tick <= 1'b1;
            @(posedge hclk);
            tick <= 1'b0;
            @(posedge hclk);
        end
        repeat (2) @(posedge hclk);
    endtask

    task automatic ev(input int b);
        core_ev[b] <= 1'b1;
        @(posedge hclk);
        core_ev[b] <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask

    task automatic zero;
        cnt = '{0, 0, 0, 0};
    endtask

    task automatic done(input string n);
        $display("test %s done", n);
    endtask

    initial begin
        #500us;
        error_cnt++;
        $display("[ERR] watchdog expected finish seen hang");
        stop_test();
    end

    initial begin
        repeat (2) @(posedge hclk);
        chk("pc held", 32'h1, {31'h0, pc_sp_reset});
        hresetn <= 1'b1;
        @(posedge hclk);
        rd("ctrl", OFF_CTRL, 32'h53);
        rd("rstsrc", OFF_RSTSRC, 32'h0);
        rd("status", OFF_STATUS, 32'h0);
        rd("unmapped", 8'h20, 32'h0);
        done("reset");
        for (int s = 0; s < 3; s++) begin
            bus(1'b1, OFF_CTRL, 32'h50 + s);
            ev(3);
            zero();
            ticks((1 << (8 + 2 * s)) - 1);
            chk("early", 32'h0, cnt[0]);
            ticks(1);
            chk("overflow", 32'h1, cnt[0]);
        end
        rd("to", OFF_STATUS, 32'h1);
        bus(1'b1, OFF_CTRL, 32'h50);
        zero();
        ce <= 1'b0;
        ticks(256);
        ce <= 1'b1;
        chk("frozen", 32'h0, cnt[0]);
        done("overflow");
        bus(1'b1, OFF_CTRL, 32'ha8);
        ev(3);
        zero();
        ticks(300);
        chk("disabled", 32'h0, cnt[0]);
        bus(1'b1, OFF_CTRL, 32'h02);
        ticks(CT - 1);
        chk("corrupt early", 32'h0, cnt[0]);
        ticks(1);
        chk("corrupt", 32'h1, cnt[0]);
        rd("ctrl reload", OFF_CTRL, 32'h53);
        rd("flag", OFF_RSTSRC, 32'h1);
        bus(1'b1, OFF_RSTSRC, 32'h1);
        rd("flag one", OFF_RSTSRC, 32'h1);
        bus(1'b1, OFF_RSTSRC, 32'h0);
        rd("flag zero", OFF_RSTSRC, 32'h0);
        done("corruption");
        bus(1'b1, OFF_CTRL, 32'h50);
        ev(2);
        rd("halt", OFF_STATUS, 32'h6);
        zero();
        ticks(256);
        chk("pc sp", 32'h1, cnt[1]);
        chk("no reset", 32'h0, cnt[0]);
        rd("halt to", OFF_STATUS, 32'h3);
        ev(3);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk("pdf clr", 32'h0, q & 32'h2);
        bus(1'b1, OFF_CTRL, 32'ha8);
        bus(1'b1, OFF_WAKE_EN, 32'h1);
        bus(1'b1, OFF_WAKE_POL, 32'h1);
        zero();
        ev(2);
        pins <= 8'h1;
        repeat (3) @(posedge hclk);
        chk("pin wake", 32'h1, cnt[2]);
        chk("awake", 32'h0, {31'h0, core_halted});
        bus(1'b1, OFF_WAKE_POL, 32'h0);
        ev(2);
        pins <= 8'h0;
        repeat (3) @(posedge hclk);
        chk("fall wake", 32'h2, cnt[2]);
        irq_en <= 8'h2;
        ev(2);
        irq_req <= 8'h2;
        repeat (3) @(posedge hclk);
        chk("service", 32'h1, cnt[3]);
        chk("service id", 32'h2, {24'h0, svc_seen});
        irq_req <= 8'h0;
        core_ev.stack_full <= 1'b1;
        ev(2);
        irq_req <= 8'h2;
        repeat (3) @(posedge hclk);
        chk("stack full", 32'h3, cnt[2]);
        irq_req <= 8'h4;
        core_ev.stack_full <= 1'b0;
        ev(2);
        repeat (4) @(posedge hclk);
        chk("pending", 32'h1, {31'h0, core_halted});
        done("wake");
        zero();
        ev(1);
        chk("usb", 32'h1, cnt[0]);
        irq_req <= 8'h0;
        ev(2);
        rst_pin_n <= 1'b0;
        @(posedge hclk);
        rst_pin_n <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("pin reset", 32'h2, cnt[0]);
        done("reset wake");
        stop_test();
    end
endmodule

`default_nettype wire
